// [common/ivsfr_pkg.sv]
// Constants, modes and carrier types of the interrupt vector and SFR block
package ivsfr_pkg;
    // ----------------------------------------------------------------
    // SFR byte offsets and decode range
    // ----------------------------------------------------------------
    localparam logic [3:0] OFS_IE1 = 4'h0;       // irq_enable_first
    localparam logic [3:0] OFS_IE2 = 4'h1;       // irq_enable_second
    localparam logic [3:0] OFS_IFG1 = 4'h2;      // irq_flag_first
    localparam logic [3:0] OFS_IFG2 = 4'h3;      // irq_flag_second
    localparam logic [3:0] OFS_ME1 = 4'h4;       // unit_enable_first
    localparam logic [3:0] OFS_ME2 = 4'h5;       // unit_enable_second
    // Implemented bits of each register
    localparam logic [7:0] IE1_MASK = 8'h33;
    localparam logic [7:0] IE2_MASK = 8'hbf;
    localparam logic [7:0] IFG1_MASK = 8'h13;
    localparam logic [7:0] IFG2_MASK = 8'hbf;
    localparam logic [7:0] ME2_MASK = 8'h30;
    localparam logic [7:0] SFR_RESET = 8'h00;    // All SFRs clear at reset
    // Field positions in the first enable and flag registers
    localparam int BIT_WDOG = 0;
    localparam int BIT_OSC = 1;
    localparam int BIT_NMI = 4;
    localparam int BIT_FLASH = 5;
    // Field positions in the second enable and flag registers
    localparam int BIT_CHA_RX = 0;
    localparam int BIT_CHA_TX = 1;
    localparam int BIT_CHB_RX = 2;
    localparam int BIT_CHB_TX = 3;
    localparam int BIT_S2_RX = 4;
    localparam int BIT_S2_TX = 5;
    localparam int BIT_TICK = 7;
    // ----------------------------------------------------------------
    // Vector area, priorities and guarded fetch range
    // ----------------------------------------------------------------
    localparam logic [15:0] VEC_BASE = 16'hffc0;  // Lowest vector word
    localparam logic [15:0] VEC_RESET = 16'hfffe; // Top vector word
    localparam logic [15:0] VEC_NMI = 16'hffcc;   // Shared non-maskable
    localparam logic [4:0] PRIO_RESET = 5'h1f;
    localparam logic [4:0] PRIO_NMI = 5'h1e;
    localparam logic [4:0] PRIO_TB0 = 5'h1d;
    localparam logic [4:0] PRIO_TBX = 5'h1c;
    localparam logic [4:0] PRIO_COMP = 5'h1b;
    localparam logic [4:0] PRIO_WDOG = 5'h1a;
    localparam logic [4:0] PRIO_RX = 5'h19;
    localparam logic [4:0] PRIO_TX = 5'h18;
    localparam logic [4:0] PRIO_ADC = 5'h17;
    localparam logic [4:0] PRIO_TA0 = 5'h16;
    localparam logic [4:0] PRIO_TAX = 5'h15;
    localparam logic [4:0] PRIO_PORT1 = 5'h14;
    localparam logic [4:0] PRIO_S2_RX = 5'h13;
    localparam logic [4:0] PRIO_S2_TX = 5'h12;
    localparam logic [4:0] PRIO_PORT2 = 5'h11;
    localparam logic [4:0] PRIO_TICK = 5'h10;
    localparam logic [4:0] PRIO_DMA = 5'h0f;
    localparam logic [4:0] PRIO_DAC = 5'h0e;      // Lowest used slot
    localparam logic [15:0] FETCH_LO = 16'h0000;  // Peripheral register space
    localparam logic [15:0] FETCH_HI = 16'h01ff;
    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_ACTIVE = 3'b000,
        MODE_SLEEP0 = 3'b001,
        MODE_SLEEP1 = 3'b010,
        MODE_SLEEP2 = 3'b011,
        MODE_SLEEP3 = 3'b100,
        MODE_SLEEP4 = 3'b101
    } ivsfr_mode_t;
    typedef struct packed {
        logic       wr;       // Byte write strobe
        logic       rd;       // Byte read strobe
        logic [3:0] addr;     // SFR byte address
        logic [7:0] wdata;    // Write byte
    } ivsfr_sfr_bus_t;
    typedef struct packed {
        logic seven_chan_timer_ch0;
        logic seven_chan_timer_rest;  // Channels 1..6 and overflow
        logic comparator_flag;
        logic adc_flag;
        logic three_chan_timer_ch0;
        logic three_chan_timer_rest;  // Channels 1..2 and overflow
        logic [7:0] port1_pin_flags;
        logic [7:0] port2_pin_flags;
        logic [2:0] dma_chan_flag;
        logic [1:0] dac_flag;
        logic flash_violation_flag;
    } ivsfr_mod_flags_t;
endpackage : ivsfr_pkg

// [rtl/ivsfr_top.sv]
// Interrupt arbitration, vector generation and byte-wide SFRs
`timescale 1ns/100ps
// Function
// RULE1 - Vectors live between ffc0 and ffff
// RULE2 - Each vector is a 16-bit handler address
// RULE3 - Reset sources share top vector, priority 31
// RULE4 - Three non-maskable sources share vector, priority 30
// RULE5 - Non-maskable gated by own enable, not global
// RULE6 - Seven-channel timer uses two vectors
// RULE7 - Serial receive merged, transmit merged below
// RULE8 - Three-channel timer uses two vectors
// RULE9 - Each port has one vector for eight pins
// RULE10 - Converter, DMA and DAC have own vectors
// RULE11 - Priority 13 and below never raised
// RULE12 - Interrupt wakes sleep, return restores mode
// RULE13 - Fetch from register space forces reset
// RULE14 - SFRs are bytes at lowest addresses
// RULE15 - First enable register bit layout
// RULE16 - Watchdog enable works only in interval mode
// RULE17 - Second enable register bit layout
// RULE18 - First flag register bit layout
// RULE19 - Watchdog flag set and clear sources
// RULE20 - Pin flag set only in non-maskable mode
// RULE21 - Second flag register mirrors enable layout
// RULE22 - Serial port unit enables at bits 5, 4
// RULE23 - Highest pending enabled request is presented
// RULE24 - Software may clear or force flags
module ivsfr_top (
    input  wire logic                       clk_in,
    input  wire logic                       resetn_in,
    input  wire ivsfr_pkg::ivsfr_sfr_bus_t  sfr_bus_in,
    output logic [7:0]                      sfr_rdata_out,
    input  wire logic                       fetch_in,
    input  wire logic [15:0]                fetch_addr_in,
    input  wire logic                       pin_nmi_mode_in,
    input  wire logic                       pin_reset_in,
    input  wire logic                       pin_nmi_event_in,
    input  wire logic                       wdog_interval_mode_in,
    input  wire logic                       wdog_overflow_in,
    input  wire logic                       wdog_interval_in,
    input  wire logic                       flash_key_violation_in,
    input  wire logic                       osc_fault_in,
    input  wire logic [7:0]                 serial_set_in,
    input  wire ivsfr_pkg::ivsfr_mod_flags_t mod_flags_in,
    input  wire logic                       gie_in,
    input  wire logic                       irq_ack_in,
    input  wire logic                       reti_in,
    input  wire logic                       sleep_in,
    input  wire ivsfr_pkg::ivsfr_mode_t     sleep_mode_in,
    output logic                            irq_req_out,
    output logic [15:0]                     irq_vector_out,
    output logic [4:0]                      irq_prio_out,
    output logic                            reset_req_out,
    output ivsfr_pkg::ivsfr_mode_t          lpm_out,
    output logic                            serial2_tx_unit_en_out,
    output logic                            serial2_rx_unit_en_out
);
    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [7:0]            ie1_q;         // irq_enable_first
    logic [7:0]            ie2_q;         // irq_enable_second
    logic [7:0]            ifg1_q;        // irq_flag_first
    logic [7:0]            ifg2_q;        // irq_flag_second
    logic [7:0]            ifg2_d;        // Next second flag byte
    logic [7:0]            me2_q;         // unit_enable_second
    logic                  rst_pend_q;    // Reset request waiting for core
    ivsfr_pkg::ivsfr_mode_t saved_q;      // Mode to resume on return
    logic [31:0]           req;           // One bit per priority slot
    logic [4:0]            best;          // Winning priority
    logic                  any;           // Some slot requests
    logic                  nmi_pend;      // Non-maskable group requests
    logic                  bad_fetch;     // Fetch into register space
    logic [7:0]            rd_mux;        // Read byte before the flop

    // Byte strobes per register
    wire wr_ie1 = sfr_bus_in.wr && sfr_bus_in.addr == ivsfr_pkg::OFS_IE1;
    wire wr_ie2 = sfr_bus_in.wr && sfr_bus_in.addr == ivsfr_pkg::OFS_IE2;
    wire wr_ifg1 = sfr_bus_in.wr && sfr_bus_in.addr == ivsfr_pkg::OFS_IFG1;
    wire wr_ifg2 = sfr_bus_in.wr && sfr_bus_in.addr == ivsfr_pkg::OFS_IFG2;
    wire wr_me2 = sfr_bus_in.wr && sfr_bus_in.addr == ivsfr_pkg::OFS_ME2;

    // ----------------------------------------------------------------
    // Enable registers
    // ----------------------------------------------------------------
    // Unused bits never store, so they read back as zero
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ie1_q <= ivsfr_pkg::SFR_RESET;
            ie2_q <= ivsfr_pkg::SFR_RESET;
            me2_q <= ivsfr_pkg::SFR_RESET;                      // RULE22
        end else begin
            if (wr_ie1) begin
                ie1_q <= sfr_bus_in.wdata & ivsfr_pkg::IE1_MASK;  // RULE15
            end
            if (wr_ie2) begin
                ie2_q <= sfr_bus_in.wdata & ivsfr_pkg::IE2_MASK;  // RULE17
            end
            if (wr_me2) begin
                me2_q <= sfr_bus_in.wdata & ivsfr_pkg::ME2_MASK;  // RULE22
            end
        end
    end

    // ----------------------------------------------------------------
    // First flag register
    // ----------------------------------------------------------------
    // Hardware set beats a software clear in the same cycle
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ifg1_q <= ivsfr_pkg::SFR_RESET;           // Power-on clears all
        end else begin
            // Watchdog flag: expiry in reset mode, key violation, interval
            if (flash_key_violation_in ||
                (wdog_overflow_in && !wdog_interval_mode_in) ||
                (wdog_interval_in && wdog_interval_mode_in)) begin
                ifg1_q[ivsfr_pkg::BIT_WDOG] <= 1'b1;                  // RULE19
            end else if (pin_reset_in && !pin_nmi_mode_in) begin
                ifg1_q[ivsfr_pkg::BIT_WDOG] <= 1'b0;                  // RULE19
            end else if (wr_ifg1) begin
                ifg1_q[ivsfr_pkg::BIT_WDOG] <= sfr_bus_in.wdata[ivsfr_pkg::BIT_WDOG]; // RULE24
            end
            // Oscillator fault flag
            if (osc_fault_in) begin
                ifg1_q[ivsfr_pkg::BIT_OSC] <= 1'b1;                   // RULE18
            end else if (wr_ifg1) begin
                ifg1_q[ivsfr_pkg::BIT_OSC] <= sfr_bus_in.wdata[ivsfr_pkg::BIT_OSC]; // RULE24
            end
            // Pin flag counts only when the pin serves non-maskable use
            if (pin_nmi_event_in && pin_nmi_mode_in) begin
                ifg1_q[ivsfr_pkg::BIT_NMI] <= 1'b1;                   // RULE20
            end else if (wr_ifg1) begin
                ifg1_q[ivsfr_pkg::BIT_NMI] <= sfr_bus_in.wdata[ivsfr_pkg::BIT_NMI]; // RULE24
            end
        end
    end

    // ----------------------------------------------------------------
    // Second flag register, one cell per bit
    // ----------------------------------------------------------------
    for (genvar b = 0; b < 8; b++) begin : g_ifg2
        always_comb begin
            if (!ivsfr_pkg::IFG2_MASK[b]) begin
                ifg2_d[b] = 1'b0;                       // Unused bit 6
            end else if (serial_set_in[b]) begin
                ifg2_d[b] = 1'b1;                       // RULE21
            end else if (wr_ifg2) begin
                ifg2_d[b] = sfr_bus_in.wdata[b];        // RULE24
            end else begin
                ifg2_d[b] = ifg2_q[b];
            end
        end
    end

    // Second flag byte storage
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ifg2_q <= ivsfr_pkg::SFR_RESET;
        end else begin
            ifg2_q <= ifg2_d;
        end
    end

    // ----------------------------------------------------------------
    // Reset request
    // ----------------------------------------------------------------
    assign bad_fetch = fetch_in && fetch_addr_in >= ivsfr_pkg::FETCH_LO &&
                       fetch_addr_in <= ivsfr_pkg::FETCH_HI;        // RULE13

    // Power-up leaves a reset pending so the core fetches the top word
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_pend_q <= 1'b1;                                     // RULE3
        end else if (bad_fetch || flash_key_violation_in ||
                     (pin_reset_in && !pin_nmi_mode_in) ||
                     (wdog_overflow_in && !wdog_interval_mode_in)) begin
            rst_pend_q <= 1'b1;                                     // RULE3
        end else if (irq_ack_in && irq_prio_out == ivsfr_pkg::PRIO_RESET) begin
            rst_pend_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Request slots by priority
    // ----------------------------------------------------------------
    // Global enable never masks this group, only its own enables do
    assign nmi_pend =
        (ifg1_q[ivsfr_pkg::BIT_NMI] && ie1_q[ivsfr_pkg::BIT_NMI]) ||
        (ifg1_q[ivsfr_pkg::BIT_OSC] && ie1_q[ivsfr_pkg::BIT_OSC]) ||
        (mod_flags_in.flash_violation_flag && ie1_q[ivsfr_pkg::BIT_FLASH]); // RULE5

    // Slots 13 down to 0 stay zero, their words hold plain code except ffcc, the slot 30 word
    always_comb begin
        req = 32'h0000_0000;                                        // RULE11
        req[ivsfr_pkg::PRIO_RESET] = rst_pend_q;                    // RULE3
        req[ivsfr_pkg::PRIO_NMI] = nmi_pend;                        // RULE4
        if (gie_in) begin
            req[ivsfr_pkg::PRIO_TB0] = mod_flags_in.seven_chan_timer_ch0;  // RULE6
            req[ivsfr_pkg::PRIO_TBX] = mod_flags_in.seven_chan_timer_rest; // RULE6
            req[ivsfr_pkg::PRIO_COMP] = mod_flags_in.comparator_flag;
            req[ivsfr_pkg::PRIO_WDOG] = ifg1_q[ivsfr_pkg::BIT_WDOG] &&
                ie1_q[ivsfr_pkg::BIT_WDOG] && wdog_interval_mode_in;       // RULE16
            req[ivsfr_pkg::PRIO_RX] =
                (ifg2_q[ivsfr_pkg::BIT_CHA_RX] && ie2_q[ivsfr_pkg::BIT_CHA_RX]) ||
                (ifg2_q[ivsfr_pkg::BIT_CHB_RX] && ie2_q[ivsfr_pkg::BIT_CHB_RX]); // RULE7
            req[ivsfr_pkg::PRIO_TX] =
                (ifg2_q[ivsfr_pkg::BIT_CHA_TX] && ie2_q[ivsfr_pkg::BIT_CHA_TX]) ||
                (ifg2_q[ivsfr_pkg::BIT_CHB_TX] && ie2_q[ivsfr_pkg::BIT_CHB_TX]); // RULE7
            req[ivsfr_pkg::PRIO_ADC] = mod_flags_in.adc_flag;              // RULE10
            req[ivsfr_pkg::PRIO_TA0] = mod_flags_in.three_chan_timer_ch0;  // RULE8
            req[ivsfr_pkg::PRIO_TAX] = mod_flags_in.three_chan_timer_rest; // RULE8
            req[ivsfr_pkg::PRIO_PORT1] = |mod_flags_in.port1_pin_flags;    // RULE9
            req[ivsfr_pkg::PRIO_S2_RX] = ifg2_q[ivsfr_pkg::BIT_S2_RX] &&
                ie2_q[ivsfr_pkg::BIT_S2_RX];
            req[ivsfr_pkg::PRIO_S2_TX] = ifg2_q[ivsfr_pkg::BIT_S2_TX] &&
                ie2_q[ivsfr_pkg::BIT_S2_TX];
            req[ivsfr_pkg::PRIO_PORT2] = |mod_flags_in.port2_pin_flags;    // RULE9
            req[ivsfr_pkg::PRIO_TICK] = ifg2_q[ivsfr_pkg::BIT_TICK] &&
                ie2_q[ivsfr_pkg::BIT_TICK];
            req[ivsfr_pkg::PRIO_DMA] = |mod_flags_in.dma_chan_flag;        // RULE10
            req[ivsfr_pkg::PRIO_DAC] = |mod_flags_in.dac_flag;             // RULE10
        end
    end

    // Ascending scan, so the highest set slot is the last to land
    always_comb begin
        best = 5'h00;
        any = 1'b0;
        for (int i = 0; i < 32; i++) begin
            if (req[i]) begin
                best = 5'(i);                                       // RULE23
                any = 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Vector output, one cycle behind the request slots
    // ----------------------------------------------------------------
    // Slot 30 sits at its own word, the rest are base plus two per slot
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            irq_req_out <= 1'b0;
            irq_prio_out <= 5'h00;
            irq_vector_out <= ivsfr_pkg::VEC_BASE;
            reset_req_out <= 1'b0;
        end else begin
            irq_req_out <= any;
            irq_prio_out <= best;
            reset_req_out <= rst_pend_q;
            if (best == ivsfr_pkg::PRIO_NMI) begin
                irq_vector_out <= ivsfr_pkg::VEC_NMI;               // RULE4
            end else begin
                irq_vector_out <= ivsfr_pkg::VEC_BASE + {10'h000, best, 1'b0}; // RULE1 RULE2
            end
        end
    end

    // ----------------------------------------------------------------
    // Operating mode: sleep, wake on accept, resume on return
    // ----------------------------------------------------------------
    // Only one level is remembered; nested handlers resume active
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            lpm_out <= ivsfr_pkg::MODE_ACTIVE;
            saved_q <= ivsfr_pkg::MODE_ACTIVE;
        end else if (irq_ack_in) begin
            lpm_out <= ivsfr_pkg::MODE_ACTIVE;                      // RULE12
            saved_q <= lpm_out;
        end else if (reti_in) begin
            lpm_out <= saved_q;                                     // RULE12
            saved_q <= ivsfr_pkg::MODE_ACTIVE;
        end else if (sleep_in) begin
            case (sleep_mode_in)
                ivsfr_pkg::MODE_SLEEP0,
                ivsfr_pkg::MODE_SLEEP1,
                ivsfr_pkg::MODE_SLEEP2,
                ivsfr_pkg::MODE_SLEEP3,
                ivsfr_pkg::MODE_SLEEP4: begin
                    lpm_out <= sleep_mode_in;
                end
                default: begin
                    lpm_out <= ivsfr_pkg::MODE_ACTIVE;              // Bad codes wake
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Byte read port
    // ----------------------------------------------------------------
    // Offsets 4 and 6..f read zero, stray writes fall away
    always_comb begin
        case (sfr_bus_in.addr)
            ivsfr_pkg::OFS_IE1: rd_mux = ie1_q;                     // RULE14
            ivsfr_pkg::OFS_IE2: rd_mux = ie2_q;
            ivsfr_pkg::OFS_IFG1: rd_mux = ifg1_q;
            ivsfr_pkg::OFS_IFG2: rd_mux = ifg2_q;
            ivsfr_pkg::OFS_ME2: rd_mux = me2_q;
            default: rd_mux = 8'h00;
        endcase
    end

    // Read byte holds until the next read strobe
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sfr_rdata_out <= 8'h00;
        end else if (sfr_bus_in.rd) begin
            sfr_rdata_out <= rd_mux;
        end
    end

    assign serial2_tx_unit_en_out = me2_q[5];
    assign serial2_rx_unit_en_out = me2_q[4];

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    property p_reset_top;
        rst_pend_q |=> irq_prio_out == 5'h1f && irq_vector_out == 16'hfffe;
    endproperty
    a_reset_top: assert property (p_reset_top) // RULE3
        else $error("Reset not presented at top word");

    property p_nmi_word;
        !rst_pend_q && nmi_pend |=> irq_vector_out == 16'hffcc && irq_req_out;
    endproperty
    a_nmi_word: assert property (p_nmi_word) // RULE4
        else $error("Non-maskable request not at its word");

    property p_nmi_no_gie;
        nmi_pend && !gie_in |=> irq_req_out && irq_prio_out >= 5'h1e;
    endproperty
    a_nmi_no_gie: assert property (p_nmi_no_gie) // RULE5
        else $error("Global enable blocked a non-maskable request");

    property p_bad_fetch;
        bad_fetch |=> rst_pend_q ##1 reset_req_out;
    endproperty
    a_bad_fetch: assert property (p_bad_fetch) // RULE13
        else $error("Register space fetch gave no reset");

    property p_floor;
        irq_req_out |-> irq_prio_out >= 5'h0e && irq_vector_out >= 16'hffc0;
    endproperty
    a_floor: assert property (p_floor) // RULE11
        else $error("Unused vector slot presented");

    property p_mask_gie;
        irq_req_out && irq_prio_out < 5'h1e |-> $past(gie_in);
    endproperty
    a_mask_gie: assert property (p_mask_gie) // RULE23
        else $error("Maskable request passed with global enable off");

    property p_wdog_mode;
        irq_req_out && irq_prio_out == 5'h1a |-> $past(wdog_interval_mode_in);
    endproperty
    a_wdog_mode: assert property (p_wdog_mode) // RULE16
        else $error("Watchdog request in reset mode");

    property p_set_wins;
        serial_set_in[0] && wr_ifg2 && !sfr_bus_in.wdata[0] |=> ifg2_q[0];
    endproperty
    a_set_wins: assert property (p_set_wins) // RULE24
        else $error("Flag set lost to a clear");

    property p_wake_resume;
        (irq_ack_in && !reti_in ##1 reti_in && !irq_ack_in) |=>
            lpm_out == $past(lpm_out, 2);
    endproperty
    a_wake_resume: assert property (p_wake_resume) // RULE12
        else $error("Mode not restored on return");

    c_reset_taken: cover property (irq_ack_in && irq_prio_out == 5'h1f);
    c_nmi_taken: cover property (irq_ack_in && irq_prio_out == 5'h1e);
    c_wake: cover property (lpm_out != ivsfr_pkg::MODE_ACTIVE ##1 irq_ack_in);
    c_serial_rx: cover property (irq_req_out && irq_prio_out == 5'h19);
endmodule : ivsfr_top

// [test/ivsfr_core_model.sv]
// Core stand-in that takes a presented reset vector
`timescale 1ns/100ps
module ivsfr_core_model (
    input  wire logic       clk_in,
    input  wire logic       irq_req_in,
    input  wire logic [4:0] prio_in,
    output logic            ack_out
);
    // One-cycle ack, only while a reset request stands
    initial ack_out = 1'b0;
    always @(negedge clk_in) begin
        ack_out <= irq_req_in && prio_in === 5'h1f && !ack_out;
    end
endmodule : ivsfr_core_model

// [test/ivsfr_tb_top.sv]
// Self-checking bench of the vector and SFR block
`timescale 1ns/100ps
module ivsfr_tb_top;
    logic        clk_in = 1'b0, resetn_in = 1'b0, ack, fet = 1'b0, osc = 1'b0, gie = 1'b0;
    logic [7:0]  ser = 8'h00, rdata, d, m [6];
    logic [15:0] fa = 16'h0000, vec;
    logic [4:0]  prio;
    logic        req, rreq;
    logic        pnm = 1'b0, pev = 1'b0, wim = 1'b0, wiv = 1'b0, reti = 1'b0, slp = 1'b0;
    logic        u2tx, u2rx;
    ivsfr_pkg::ivsfr_mode_t      smode = ivsfr_pkg::MODE_SLEEP3, lpm;
    ivsfr_pkg::ivsfr_mod_flags_t mf = '0;
    ivsfr_pkg::ivsfr_sfr_bus_t b = '0;
    integer      fails = 0, checks_done = 0, seed = 64, i;
    // Free-running 10 MHz clock
    always #50 clk_in = ~clk_in;
    ivsfr_top u_dut (.clk_in(clk_in), .resetn_in(resetn_in), .sfr_bus_in(b),
        .sfr_rdata_out(rdata), .fetch_in(fet), .fetch_addr_in(fa), .pin_nmi_mode_in(pnm),
        .pin_reset_in(1'b0), .pin_nmi_event_in(pev), .wdog_interval_mode_in(wim),
        .wdog_overflow_in(1'b0), .wdog_interval_in(wiv), .flash_key_violation_in(1'b0),
        .osc_fault_in(osc), .serial_set_in(ser), .mod_flags_in(mf), .gie_in(gie),
        .irq_ack_in(ack), .reti_in(reti), .sleep_in(slp), .sleep_mode_in(smode),
        .irq_req_out(req), .irq_vector_out(vec), .irq_prio_out(prio), .reset_req_out(rreq),
        .lpm_out(lpm), .serial2_tx_unit_en_out(u2tx), .serial2_rx_unit_en_out(u2rx));
    ivsfr_core_model u_core (.clk_in(clk_in), .irq_req_in(req), .prio_in(prio), .ack_out(ack));
    // Expected vector word of a priority slot
    function automatic logic [15:0] ev(input integer p);
        ev = p == 31 ? 16'hfffe : p == 30 ? 16'hffcc : 16'hffc0 + 2 * p;
    endfunction : ev
    task chk(input logic [15:0] s, input logic [15:0] e);
        checks_done++;
        if (s !== e) begin
            fails++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task cyc(input integer n);
        repeat (n) @(negedge clk_in);
    endtask : cyc
    // Byte write, strobe held for one edge
    task wr(input logic [3:0] a, input logic [7:0] v);
        @(negedge clk_in) b = '{1'b1, 1'b0, a, v};
        @(negedge clk_in) b = '0;
    endtask : wr
    // Byte read, data sampled once settled
    task rd(input logic [3:0] a, input logic [7:0] e);
        @(negedge clk_in) b = '{1'b0, 1'b1, a, 8'h00};
        @(negedge clk_in) b = '0;
        chk({8'h00, rdata}, {8'h00, e});
    endtask : rd
    task give_verdict;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict
    // Hang guard
    initial begin
        #400000;
        fails++;
        give_verdict();
    end
    initial begin
        m = '{ivsfr_pkg::IE1_MASK, ivsfr_pkg::IE2_MASK, ivsfr_pkg::IFG1_MASK,
              ivsfr_pkg::IFG2_MASK, 8'h00, ivsfr_pkg::ME2_MASK};
        cyc(10);
        resetn_in = 1'b1;
        cyc(1);
        chk({prio, 10'h000, rreq}, {5'h1f, 10'h000, 1'b1});
        cyc(4);
        // Reset values, then random bytes through the implemented bits only
        for (i = 0; i < 6; i++) begin
            rd(i[3:0], 8'h00);
            d = 8'($random(seed));
            wr(i[3:0], d);
            rd(i[3:0], d & m[i]);
        end
        chk({14'h0000, u2tx, u2rx}, {14'h0000, d[5], d[4]});
        for (i = 0; i < 6; i++) wr(i[3:0], 8'h00);
        // Serial flags merge by direction
        wr(4'h1, 8'hbf);
        gie = 1'b1;
        for (i = 0; i < 4; i++) begin
            @(negedge clk_in) ser = 8'h01 << i;
            @(negedge clk_in) ser = 8'h00;
            cyc(2);
            chk(vec, ev(i[0] ? 24 : 25));
            wr(4'h3, 8'h00);
        end
        // Watchdog interval request, gated by the timer mode
        wim = 1'b1;
        wr(4'h0, 8'h01);
        @(negedge clk_in) wiv = 1'b1;
        @(negedge clk_in) wiv = 1'b0;
        cyc(2);
        chk(vec, ev(26));
        wim = 1'b0;
        cyc(2);
        chk({15'h0000, req}, 16'h0000);
        // Any port 2 pin flag raises the one port vector
        mf.port2_pin_flags = d | 8'h01;
        cyc(2);
        chk(vec, ev(17));
        mf = '0;
        // Non-maskable source ignores the global enable
        wr(4'h1, 8'h00);
        gie = 1'b0;
        wr(4'h0, 8'h12);
        // Pin event counts only in non-maskable pin mode
        @(negedge clk_in) pev = 1'b1;
        @(negedge clk_in) pev = 1'b0;
        cyc(2);
        chk({15'h0000, req}, 16'h0000);
        pnm = 1'b1;
        @(negedge clk_in) pev = 1'b1;
        @(negedge clk_in) pev = 1'b0;
        cyc(2);
        chk(vec, ev(30));
        wr(4'h2, 8'h00);
        @(negedge clk_in) osc = 1'b1;
        @(negedge clk_in) osc = 1'b0;
        cyc(2);
        chk(vec, ev(30));
        chk({11'h000, prio}, {11'h000, 5'h1e});
        // Sleep and a fetch from register space in the same cycle; the fetch asks for reset
        @(negedge clk_in) begin
            fet = 1'b1;
            fa = 16'h01ff;
            slp = 1'b1;
        end
        @(negedge clk_in) begin
            fet = 1'b0;
            slp = 1'b0;
        end
        cyc(1);
        chk({15'h0000, rreq}, 16'h0001);
        chk({13'h0000, lpm}, {13'h0000, ivsfr_pkg::MODE_SLEEP3});
        // Core takes the reset word, which wakes; return resumes the sleep
        @(negedge clk_in) reti = 1'b1;
        chk({13'h0000, lpm}, {13'h0000, ivsfr_pkg::MODE_ACTIVE});
        @(negedge clk_in) reti = 1'b0;
        chk({13'h0000, lpm}, {13'h0000, ivsfr_pkg::MODE_SLEEP3});
        cyc(5);
        give_verdict();
    end
endmodule : ivsfr_tb_top
